// ### src/rtca_serial_top.sv
/*
 * Three-wire serial access port with the alarm register file behind it.
 * Assumes the chip enable, serial clock and data pins are asynchronous to
 * clk_sys and toggle far slower than it; the pins are oversampled.
 */
//
// Behaviour
// [R1] Clock low at enable rise: drive on rising, sample on falling edges.
// [R2] Clock high at enable rise: drive on falling, sample on rising edges.
// [R3] Session opens on enable rising and closes on enable falling.
// [R4] Whole bytes; control byte gives head address high, format low.
// [R5] Every byte is shifted most significant bit first.
// [R6] Format 8h writes one byte at the pointer address.
// [R7] After a single transfer a new control byte may follow.
// [R8] Format 0h is burst write; pointer steps per byte, wraps Fh to 0h.
// [R9] Burst runs as long as the host clocks, until enable falls.
// [R10] Hour bit 5 is PM flag in 12-hour, tens-of-20 in 24-hour.
// [R11] In 12-hour mode midnight is code 12, noon is code 32.
// [R12] Weekday enable bits map to weekday values 0 to 6.
// [R13] All weekday enables clear means no weekly alarm output.
// [R14] Host must not load impossible minute or hour alarm values.
// [R15] Oscillator halt leaves alarm data undefined; unused bits read 0.
// [R16] Unused upper alarm bits ignore writes and read zero.
// [R17] Ch is single read; 4h is burst read with wrapping pointer.
// [R18] Time carries held while enable high, at most one second.
// [R19] Minute, hour, weekday matches raise alarm events; daily skips weekday.
`timescale 1ns/1ns
module rtca_serial_top
   import rtca_pkg::*;
#(
   parameter int HOLD_CYCLES = CARRY_HOLD_CYCLES
)
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Serial pins
   input  wire logic       chip_enable,
   input  wire logic       serial_clk,
   input  wire logic       bidir_data_pin_in,
   output logic            bidir_data_pin_out,
   output logic            bidir_data_pin_oe,
   // Time counters and control
   input  wire logic [7:0] cur_minute,
   input  wire logic [7:0] cur_hour,
   input  wire logic [2:0] cur_weekday,
   input  wire logic       weekly_alarm_enable,
   input  wire logic       daily_alarm_enable,
   input  wire logic       osc_halt_flag,
   // Alarm events and carry hold
   output logic            weekly_alarm_event,
   output logic            daily_alarm_event,
   output logic            carry_hold
);

   // Elaboration check: the hold counter is only 25 bits wide
   if (HOLD_CYCLES < 1 || HOLD_CYCLES > 33_554_431) begin
      $error("HOLD_CYCLES out of range");
   end

   typedef struct packed {
      logic           ce_s1;
      logic           ce_s2;
      logic           ce_d;
      logic           sclk_s1;
      logic           sclk_s2;
      logic           sclk_d;
      logic           sio_s1;
      logic           sio_s2;
      logic           mode;
      rtca_phase_type phase;
      logic [2:0]     bits;
      logic [7:0]     shreg;
      logic [7:0]     tx;
      logic [3:0]     addr;
      logic [3:0]     fmt;
      logic           sio_out;
      logic           hold;
      logic [24:0]    hold_cnt;
   } rtca_port_state_type;

   rtca_port_state_type st;
   rtca_port_state_type next_st;
   rtca_alarm_if        bus ();

   logic       rst_m;
   logic       rst_n_sync;
   logic       ce_rise;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       sample_edge;
   logic       drive_edge;
   logic [7:0] in_byte;
   logic       wr_en;

   // ---------------------------------------------------------------------
   // Reset release synchroniser
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_m      <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_m      <= 1'b1;
         rst_n_sync <= rst_m;
      end
   end

   // ---------------------------------------------------------------------
   // Pin edges, taken only from the second synchroniser stage onward
   // ---------------------------------------------------------------------
   assign ce_rise     = st.ce_s2 && !st.ce_d;                     // R3
   assign sclk_rise   = st.sclk_s2 && !st.sclk_d;
   assign sclk_fall   = !st.sclk_s2 && st.sclk_d;
   assign sample_edge = st.mode ? sclk_rise : sclk_fall;          // R1 R2
   assign drive_edge  = st.mode ? sclk_fall : sclk_rise;          // R1 R2
   assign in_byte     = {st.shreg[6:0], st.sio_s2};               // R5

   // ---------------------------------------------------------------------
   // Serial engine
   // ---------------------------------------------------------------------
   always_comb begin
      next_st = st;
      wr_en   = 1'b0;
      next_st.ce_s1   = chip_enable;
      next_st.ce_s2   = st.ce_s1;
      next_st.ce_d    = st.ce_s2;
      next_st.sclk_s1 = serial_clk;
      next_st.sclk_s2 = st.sclk_s1;
      next_st.sclk_d  = st.sclk_s2;
      next_st.sio_s1  = bidir_data_pin_in;
      next_st.sio_s2  = st.sio_s1;
      if (ce_rise) begin
         // Edge polarity is latched once and kept for the session
         next_st.mode     = st.sclk_s2;                          // R1 R2
         next_st.phase    = PH_CMD;                              // R3
         next_st.bits     = 3'd0;
         next_st.hold     = 1'b1;                                // R18
         next_st.hold_cnt = '0;
      end else if (!st.ce_s2) begin
         // Enable low ends everything, mid-byte included
         next_st.phase   = PH_IDLE;                              // R3 R9
         next_st.hold    = 1'b0;                                 // R18
         next_st.sio_out = 1'b0;
      end else begin
         // Carries may not stall past one second even if enable sticks
         if (st.hold) begin
            if (st.hold_cnt == 25'(HOLD_CYCLES - 1)) begin
               next_st.hold = 1'b0;                              // R18
            end else begin
               next_st.hold_cnt = st.hold_cnt + 25'd1;
            end
         end
         if (sample_edge && st.phase != PH_IDLE) begin
            next_st.shreg = in_byte;                             // R5
            next_st.bits  = st.bits + 3'd1;                      // R4
            if (st.bits == 3'd7) begin
               case (st.phase)
                  PH_CMD: begin
                     next_st.addr = in_byte[7:4];                // R4
                     next_st.fmt  = in_byte[3:0];                // R4
                     case (in_byte[3:0])
                        FMT_WR_SINGLE, FMT_WR_BURST: begin
                           next_st.phase = PH_WDATA;             // R6 R8
                        end
                        FMT_RD_SINGLE, FMT_RD_BURST: begin
                           next_st.phase = PH_RDATA;             // R17
                           next_st.tx    = bus.rd_data;
                        end
                        // Unknown formats park until enable falls
                        default: next_st.phase = PH_IDLE;
                     endcase
                  end
                  PH_WDATA: begin
                     wr_en = 1'b1;                               // R6 R8
                     if (st.fmt == FMT_WR_BURST) begin
                        next_st.addr = st.addr + 4'd1;           // R8 R9
                     end else begin
                        next_st.phase = PH_CMD;                  // R7
                     end
                  end
                  PH_RDATA: begin
                     if (st.fmt == FMT_RD_BURST) begin
                        next_st.addr = st.addr + 4'd1;           // R17 R9
                        next_st.tx   = bus.rd_data;
                     end else begin
                        next_st.phase = PH_CMD;                  // R7
                     end
                  end
                  default: next_st.phase = PH_IDLE;
               endcase
            end
         end
         if (drive_edge && st.phase == PH_RDATA) begin
            next_st.sio_out = st.tx[7];                          // R5 R1 R2
            next_st.tx      = {st.tx[6:0], 1'b0};
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Register channel; read address looks ahead to the byte to be loaded
   assign bus.wr_en   = wr_en;
   assign bus.wr_addr = st.addr;
   assign bus.wr_data = in_byte;
   assign bus.rd_addr = (st.phase == PH_CMD) ? in_byte[7:4]
                                             : st.addr + 4'd1;   // R17

   rtca_alarm_regs rtca_alarm_regs_inst (
      .clk_sys             (clk_sys),
      .rst_n_sync          (rst_n_sync),
      .bus                 (bus.regs),
      .cur_minute          (cur_minute),
      .cur_hour            (cur_hour),
      .cur_weekday         (cur_weekday),
      .weekly_alarm_enable (weekly_alarm_enable),
      .daily_alarm_enable  (daily_alarm_enable),
      .osc_halt_flag       (osc_halt_flag),
      .weekly_alarm_event  (weekly_alarm_event),
      .daily_alarm_event   (daily_alarm_event)
   );

   // Outputs; data line driven only while a read byte is in flight
   assign bidir_data_pin_out = st.sio_out;
   assign bidir_data_pin_oe  = (st.phase == PH_RDATA);
   assign carry_hold         = st.hold;                          // R18

endmodule

// ### src/rtca_pkg.sv
/*
 * Shared constants for the three-wire access port and its alarm registers:
 * register offsets, field masks, transfer format codes and timing figures.
 * Assumes a single 25 MHz system clock drives every module that imports it.
 */
package rtca_pkg;

   // ---------------------------------------------------------------------
   // Register offsets (4-bit address pointer space)
   // ---------------------------------------------------------------------
   localparam logic [3:0] ADDR_W_MINUTE = 4'h8;
   localparam logic [3:0] ADDR_W_HOUR   = 4'h9;
   localparam logic [3:0] ADDR_W_DAYS   = 4'ha;
   localparam logic [3:0] ADDR_D_MINUTE = 4'hb;
   localparam logic [3:0] ADDR_D_HOUR   = 4'hc;

   // ---------------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------------
   localparam logic [7:0] MINUTE_MASK  = 8'h7f;  // Bit 7 unused
   localparam logic [7:0] HOUR_MASK    = 8'h3f;  // Bits 7..6 unused
   localparam logic [7:0] DAYS_MASK    = 8'h7f;  // Bit 7 unused
   localparam int         HOUR_PM_BIT  = 5;      // PM flag or tens-of-20
   localparam logic [7:0] ALARM_RESET  = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ---------------------------------------------------------------------
   // Transfer format codes (low nibble of a control byte)
   // ---------------------------------------------------------------------
   localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
   localparam logic [3:0] FMT_WR_BURST  = 4'h0;
   localparam logic [3:0] FMT_RD_SINGLE = 4'hc;
   localparam logic [3:0] FMT_RD_BURST  = 4'h4;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int CLK_FREQ_HZ      = 25_000_000;
   localparam int CARRY_HOLD_MS    = 1000;
   // Longest time, so rounded down
   localparam int CARRY_HOLD_CYCLES = (CLK_FREQ_HZ / 1000) * CARRY_HOLD_MS;

   // Serial session phase
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_CMD   = 2'b01,
      PH_WDATA = 2'b10,
      PH_RDATA = 2'b11
   } rtca_phase_type;

endpackage

// ### src/rtca_alarm_if.sv
/*
 * Register access channel between the serial engine and the alarm file.
 * Assumes both ends run on the system clock; writes are one-cycle strobes.
 */
`timescale 1ns/1ns
interface rtca_alarm_if;
   logic       wr_en;
   logic [3:0] wr_addr;
   logic [7:0] wr_data;
   logic [3:0] rd_addr;
   logic [7:0] rd_data;

   modport engine (output wr_en, output wr_addr, output wr_data,
                   output rd_addr, input rd_data);
   modport regs   (input wr_en, input wr_addr, input wr_data,
                   input rd_addr, output rd_data);
endinterface

// ### src/rtca_alarm_regs.sv
/*
 * Weekly and daily alarm registers with their time comparators.
 * Assumes current minute, hour and weekday come from the time counters on
 * the same clock, and the halt flag is a synchronous level.
 */
`timescale 1ns/1ns
module rtca_alarm_regs
   import rtca_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n_sync,
   // Register channel
   rtca_alarm_if.regs      bus,
   // Time counters and control
   input  wire logic [7:0] cur_minute,
   input  wire logic [7:0] cur_hour,
   input  wire logic [2:0] cur_weekday,
   input  wire logic       weekly_alarm_enable,
   input  wire logic       daily_alarm_enable,
   input  wire logic       osc_halt_flag,
   // Alarm events
   output logic            weekly_alarm_event,
   output logic            daily_alarm_event
);

   typedef struct packed {
      logic [7:0] w_minute;
      logic [7:0] w_hour;
      logic [7:0] w_days;
      logic [7:0] d_minute;
      logic [7:0] d_hour;
      logic       halt_d;
      logic       w_hit;
      logic       d_hit;
      logic       w_event;
      logic       d_event;
   } rtca_alarm_state_type;

   rtca_alarm_state_type st;
   rtca_alarm_state_type next_st;
   logic                 w_match;
   logic                 d_match;

   // ---------------------------------------------------------------------
   // Next state: writes, halt clearing, comparison
   // ---------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.halt_d = osc_halt_flag;
      // Unused upper bits are dropped here so they always read zero
      if (bus.wr_en) begin
         case (bus.wr_addr)
            ADDR_W_MINUTE: next_st.w_minute = bus.wr_data & MINUTE_MASK; // R16
            ADDR_W_HOUR:   next_st.w_hour   = bus.wr_data & HOUR_MASK;   // R16
            ADDR_W_DAYS:   next_st.w_days   = bus.wr_data & DAYS_MASK;   // R16
            ADDR_D_MINUTE: next_st.d_minute = bus.wr_data & MINUTE_MASK; // R16
            ADDR_D_HOUR:   next_st.d_hour   = bus.wr_data & HOUR_MASK;   // R16
            default: ;
         endcase
      end
      // Halt means contents are no longer trusted; zero is one legal value
      if (osc_halt_flag && !st.halt_d) begin
         next_st.w_minute = ALARM_RESET; // R15
         next_st.w_hour   = ALARM_RESET; // R15
         next_st.w_days   = ALARM_RESET; // R15
         next_st.d_minute = ALARM_RESET; // R15
         next_st.d_hour   = ALARM_RESET; // R15
      end
      // Hour bytes compare raw, so bit 5 and the 12/32 codes need no decode
      w_match = weekly_alarm_enable && (cur_minute == st.w_minute)
              && (cur_hour == st.w_hour)                 // R10 R11 R19
              && (cur_weekday != 3'd7)
              && st.w_days[cur_weekday];                 // R12 R13
      d_match = daily_alarm_enable && (cur_minute == st.d_minute)
              && (cur_hour == st.d_hour);                // R10 R11 R19
      // One event per match interval, not one per cycle
      next_st.w_hit   = w_match;
      next_st.d_hit   = d_match;
      next_st.w_event = w_match && !st.w_hit; // R19
      next_st.d_event = d_match && !st.d_hit; // R19
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      case (bus.rd_addr)
         ADDR_W_MINUTE: bus.rd_data = st.w_minute;
         ADDR_W_HOUR:   bus.rd_data = st.w_hour;
         ADDR_W_DAYS:   bus.rd_data = st.w_days;
         ADDR_D_MINUTE: bus.rd_data = st.d_minute;
         ADDR_D_HOUR:   bus.rd_data = st.d_hour;
         default:       bus.rd_data = READ_UNMAPPED;
      endcase
   end

   assign weekly_alarm_event = st.w_event;
   assign daily_alarm_event  = st.d_event;

endmodule

// ### verification/rtca_serial_asserts.sv
/* Checker for the three-wire port and the alarm events; it sees only
   the top ports. Assumes rst_b resets asynchronously and clk_sys samples. */
`timescale 1ns/1ns
module rtca_serial_asserts #(
   parameter int HOLD_CYCLES = 200
)
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // Serial side
   input wire logic       chip_enable,
   input wire logic       bidir_data_pin_oe,
   input wire logic       carry_hold,
   // Alarm side
   input wire logic [2:0] cur_weekday,
   input wire logic       weekly_alarm_enable,
   input wire logic       daily_alarm_enable,
   input wire logic       weekly_alarm_event,
   input wire logic       daily_alarm_event
);
   // ---------------------------------------------------------------
   // Run length of carry hold; a counter keeps the bound cheap
   // ---------------------------------------------------------------
   int hold_cnt;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hold_cnt <= 0;
      end else begin
         hold_cnt <= carry_hold ? hold_cnt + 1 : 0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_ce_oe;
      !chip_enable [*6] |-> !bidir_data_pin_oe;
   endproperty
   a_ce_oe: assert property (p_ce_oe)
      else $error("pin driven outside a session");
   property p_hold_rise;
      $rose(chip_enable) |-> ##[1:8] carry_hold;
   endproperty
   a_hold_rise: assert property (p_hold_rise)
      else $error("carry hold missing after enable");
   property p_hold_ce;
      !chip_enable [*6] |-> !carry_hold;
   endproperty
   a_hold_ce: assert property (p_hold_ce)
      else $error("carry hold while idle");
   property p_hold_max;
      hold_cnt <= HOLD_CYCLES;
   endproperty
   a_hold_max: assert property (p_hold_max)
      else $error("carry hold too long");
   property p_w_pulse;
      weekly_alarm_event |=> !weekly_alarm_event;
   endproperty
   a_w_pulse: assert property (p_w_pulse)
      else $error("weekly event longer than a cycle");
   property p_d_pulse;
      daily_alarm_event |=> !daily_alarm_event;
   endproperty
   a_d_pulse: assert property (p_d_pulse)
      else $error("daily event longer than a cycle");
   property p_w_en;
      !weekly_alarm_enable [*3] |-> !weekly_alarm_event;
   endproperty
   a_w_en: assert property (p_w_en)
      else $error("weekly event while disabled");
   property p_d_en;
      !daily_alarm_enable [*3] |-> !daily_alarm_event;
   endproperty
   a_d_en: assert property (p_d_en)
      else $error("daily event while disabled");
   property p_wday7;
      (cur_weekday == 3'h7) [*3] |-> !weekly_alarm_event;
   endproperty
   a_wday7: assert property (p_wday7)
      else $error("weekly event on weekday 7");
   c_week: cover property (weekly_alarm_event);
   c_day: cover property (daily_alarm_event);
   c_hold: cover property ($fell(carry_hold) && chip_enable);
endmodule
bind rtca_serial_top rtca_serial_asserts #(.HOLD_CYCLES(HOLD_CYCLES))
   rtca_serial_asserts_inst (
   .clk_sys(clk_sys), .rst_b(rst_b), .chip_enable(chip_enable),
   .bidir_data_pin_oe(bidir_data_pin_oe), .carry_hold(carry_hold),
   .cur_weekday(cur_weekday), .weekly_alarm_enable(weekly_alarm_enable),
   .daily_alarm_enable(daily_alarm_enable),
   .weekly_alarm_event(weekly_alarm_event),
   .daily_alarm_event(daily_alarm_event));

// ### verification/rtca_host_model.sv
/* Host model: frames sessions and shifts bytes on the three-wire port.
   Assumes clk_sys at 25 MHz; the serial clock half period is 4 cycles. */
`timescale 1ns/1ns
module rtca_host_model (
   // Clock
   input  wire logic clk_sys,
   // Device side of the data pin
   input  wire logic dev_out,
   input  wire logic dev_oe,
   // Pin levels seen by the device
   output logic      chip_enable,
   output logic      serial_clk,
   output logic      data_line
);
   logic host_oe, host_bit, idle_bit, mode;
   // Released line toggles, so a stale bit is never read as good
   assign data_line = dev_oe ? dev_out : (host_oe ? host_bit : idle_bit);
   initial begin
      {chip_enable, serial_clk, host_oe, host_bit, idle_bit, mode} = '0;
   end
   always @(posedge clk_sys) idle_bit <= ~idle_bit;
   // ---------------------------------------------------------------
   // Session framing; clock stands still outside sessions
   // ---------------------------------------------------------------
   task automatic open_s(input logic m);
      @(posedge clk_sys);
      mode <= m;
      serial_clk <= m;
      repeat (4) @(posedge clk_sys);
      chip_enable <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic close_s();
      repeat (4) @(posedge clk_sys);
      chip_enable <= 1'b0;
      host_oe <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   // Whole byte, MSB first; a read leaves the line to the device
   task automatic xfer(input logic [7:0] w, input logic rd,
                       output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_sys);
         serial_clk <= ~mode;
         host_oe <= ~rd;
         host_bit <= w[i];
         repeat (4) @(posedge clk_sys);
         serial_clk <= mode;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         r[i] = data_line;
         @(posedge clk_sys);
      end
   endtask
endmodule

// ### verification/rtca_serial_top_bench.sv
/* Bench for the three-wire port with the alarm registers behind it.
   Assumes the host model drives the pins; carry hold is cut to 200. */
`timescale 1ns/1ns
module rtca_serial_top_bench
   import rtca_pkg::*;
;
   localparam int HOLD = 200;
   logic       clk_sys     = 1'b0;
   logic       rst_b       = 1'b0;
   logic [7:0] cur_minute;
   logic [7:0] cur_hour;
   logic [2:0] cur_weekday;
   logic       w_en;
   logic       d_en;
   logic       halt;
   logic       ce, sclk, pin, dout, doe, w_ev, d_ev, carry;
   int         n_errors    = 0;
   int         tests_run   = 0;
   always #20 clk_sys = ~clk_sys;
   rtca_serial_top #(.HOLD_CYCLES(HOLD)) rtca_serial_top_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .chip_enable(ce),
      .serial_clk(sclk), .bidir_data_pin_in(pin),
      .bidir_data_pin_out(dout), .bidir_data_pin_oe(doe),
      .cur_minute(cur_minute), .cur_hour(cur_hour),
      .cur_weekday(cur_weekday), .weekly_alarm_enable(w_en),
      .daily_alarm_enable(d_en), .osc_halt_flag(halt),
      .weekly_alarm_event(w_ev), .daily_alarm_event(d_ev),
      .carry_hold(carry));
   rtca_host_model rtca_host_model_inst (
      .clk_sys(clk_sys), .dev_out(dout), .dev_oe(doe),
      .chip_enable(ce), .serial_clk(sclk), .data_line(pin));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h, expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic xb(input logic [7:0] w, input logic rd,
                     output logic [7:0] r);
      rtca_host_model_inst.xfer(w, rd, r);
   endtask
   task automatic wr1(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      xb({a, FMT_WR_SINGLE}, 1'b0, r);
      xb(d, 1'b0, r);
   endtask
   task automatic rd1(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] r;
      xb({a, FMT_RD_SINGLE}, 1'b0, r);
      xb(8'h00, 1'b1, r);
      chk(r, e);
   endtask
   // Counts pulses over a short window once the time inputs move
   task automatic pulses(input logic [7:0] mn, input logic [7:0] hr,
      input logic [2:0] wd, input logic [1:0] e, input int ew, ed);
      int nw, nd;
      nw = 0;
      nd = 0;
      @(posedge clk_sys);
      cur_minute  <= mn;
      cur_hour    <= hr;
      cur_weekday <= wd;
      w_en        <= e[0];
      d_en        <= e[1];
      repeat (10) begin
         @(negedge clk_sys);
         if (w_ev === 1'b1) nw++;
         if (d_ev === 1'b1) nd++;
      end
      chk(8'(nw), 8'(ew));
      chk(8'(nd), 8'(ed));
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_single();
      logic [7:0] r;
      chk({5'h00, doe, carry, w_ev | d_ev}, 8'h00);
      rtca_host_model_inst.open_s(1'b0);
      chk({7'h00, carry}, 8'h01);
      rd1(ADDR_D_MINUTE, ALARM_RESET);
      wr1(ADDR_D_MINUTE, 8'h25);
      rd1(ADDR_D_MINUTE, 8'h25);
      wr1(ADDR_D_HOUR, 8'hff);
      rd1(ADDR_D_HOUR, 8'h3f);
      wr1(ADDR_W_DAYS, 8'hff);
      rd1(ADDR_W_DAYS, 8'h7f);
      wr1(4'h3, 8'h55);
      rd1(4'h3, READ_UNMAPPED);
      xb({ADDR_D_MINUTE, 4'h2}, 1'b0, r);
      xb(8'h99, 1'b0, r);
      rtca_host_model_inst.close_s();
   endtask
   task automatic t_burst();
      logic [7:0] r;
      logic [7:0] bexp [5] = '{8'h2d, 8'h2e, 8'h7f, 8'h25, 8'h21};
      rtca_host_model_inst.open_s(1'b1);
      xb({ADDR_D_HOUR, FMT_WR_BURST}, 1'b0, r);
      for (int i = 0; i < 14; i++) xb(8'h21 + 8'(i), 1'b0, r);
      // Enable stuck high past the limit must release the carries
      repeat (HOLD) @(posedge clk_sys);
      chk({7'h00, carry}, 8'h00);
      rtca_host_model_inst.close_s();
      rtca_host_model_inst.open_s(1'b1);
      xb({ADDR_W_MINUTE, FMT_RD_BURST}, 1'b0, r);
      for (int i = 0; i < 5; i++) begin
         xb(8'h00, 1'b1, r);
         chk(r, bexp[i]);
      end
      rtca_host_model_inst.close_s();
   endtask
   task automatic t_alarm();
      rtca_host_model_inst.open_s(1'b0);
      wr1(ADDR_W_MINUTE, 8'h30);
      wr1(ADDR_W_HOUR, 8'h12);
      wr1(ADDR_W_DAYS, 8'h05);
      wr1(ADDR_D_MINUTE, 8'h59);
      wr1(ADDR_D_HOUR, 8'h32);
      rtca_host_model_inst.close_s();
      pulses(8'h30, 8'h12, 3'd1, 2'b11, 0, 0);
      pulses(8'h30, 8'h12, 3'd2, 2'b11, 1, 0);
      pulses(8'h30, 8'h12, 3'd7, 2'b11, 0, 0);
      pulses(8'h30, 8'h12, 3'd2, 2'b10, 0, 0);
      pulses(8'h59, 8'h32, 3'd3, 2'b01, 0, 0);
      pulses(8'h59, 8'h32, 3'd3, 2'b11, 0, 1);
      rtca_host_model_inst.open_s(1'b0);
      wr1(ADDR_W_DAYS, 8'h00);
      rtca_host_model_inst.close_s();
      pulses(8'h30, 8'h12, 3'd0, 2'b11, 0, 0);
      halt <= 1'b1;
      repeat (4) @(posedge clk_sys);
      halt <= 1'b0;
      rtca_host_model_inst.open_s(1'b0);
      rd1(ADDR_D_HOUR, ALARM_RESET);
      rtca_host_model_inst.close_s();
   endtask
   // Reset for three cycles, then every scenario in turn
   initial begin
      cur_minute  <= 8'h00;
      cur_hour    <= 8'h00;
      cur_weekday <= 3'h0;
      w_en        <= 1'b0;
      d_en        <= 1'b0;
      halt        <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk_sys);
      t_single();
      t_burst();
      t_alarm();
      stop_test();
   end
endmodule
